// File: design/acr_pkg.sv
// Constants and types of the converter control register bank
// Function
// - Per-channel writes reach only selected channels
// - All other registers except rate override act on write
// - Rate override applies on transfer bit 0
// - Mode 00 runs all channels normally
// - Mode 01 stops clocks, resets, disables outputs
// - Mode 10 standby without datapath reset
// - Mode 11 resets datapath, serial port untouched
// - Only power-on reset resets serial port
// - Power mode bit 5 picks pin action
// - Clock bit 0 disables stabilizer, resets to one
// - Without serial port the stabilizer is on
// - Enhancement bit 2 enables chopping
// - Output mode bit 6 picks reduced range
// - Output mode bit 2 inverts stream
// - Output mode bit 0 twos complement default
// - Adjust bit 0 doubles selected clock drive
// - Termination overrides double drive
package acr_pkg;
  localparam int ACR_AW = 13;
  localparam logic [12:0] ACR_IDX_A = 13'h0004;
  localparam logic [12:0] ACR_IDX_B = 13'h0005;
  localparam logic [12:0] ACR_PWR = 13'h0008;
  localparam logic [12:0] ACR_CLK = 13'h0009;
  localparam logic [12:0] ACR_ENH = 13'h000C;
  localparam logic [12:0] ACR_OMODE = 13'h0014;
  localparam logic [12:0] ACR_OADJ = 13'h0015;
  localparam logic [12:0] ACR_OPHASE = 13'h0016;
  localparam logic [12:0] ACR_CHPWR = 13'h0022;
  localparam logic [12:0] ACR_XFER = 13'h00FF;
  localparam logic [12:0] ACR_RATE = 13'h0100;
  localparam logic [12:0] ACR_IO2 = 13'h0101;
  localparam logic [12:0] ACR_IO3 = 13'h0102;
  localparam logic [12:0] ACR_SYNC = 13'h0109;
  // Writable bit masks
  localparam logic [7:0] ACR_M_IDX_A = 8'h0F;
  localparam logic [7:0] ACR_M_IDX_B = 8'h3F;
  localparam logic [7:0] ACR_M_PWR = 8'h23;
  localparam logic [7:0] ACR_M_CLK = 8'h01;
  localparam logic [7:0] ACR_M_ENH = 8'h04;
  localparam logic [7:0] ACR_M_OMODE = 8'h45;
  localparam logic [7:0] ACR_M_OADJ = 8'h31;
  localparam logic [7:0] ACR_M_OPHASE = 8'h7F;
  localparam logic [7:0] ACR_M_CHPWR = 8'h03;
  localparam logic [7:0] ACR_M_RATE = 8'h47;
  localparam logic [7:0] ACR_M_IO2 = 8'h01;
  localparam logic [7:0] ACR_M_IO3 = 8'h08;
  localparam logic [7:0] ACR_M_SYNC = 8'h03;
  // Reset values
  localparam logic [7:0] ACR_R_IDX_A = 8'h0F;
  localparam logic [7:0] ACR_R_IDX_B = 8'h3F;
  localparam logic [7:0] ACR_R_CLK = 8'h01;
  localparam logic [7:0] ACR_R_OMODE = 8'h01;
  localparam logic [7:0] ACR_R_OPHASE = 8'h03;
  localparam logic [7:0] ACR_R_ZERO = 8'h00;
  // Field positions
  localparam int ACR_B_PINSTBY = 5;
  localparam int ACR_B_DCS = 0;
  localparam int ACR_B_CHOP = 2;
  localparam int ACR_B_RANGE = 6;
  localparam int ACR_B_INV = 2;
  localparam int ACR_B_TWOS = 0;
  localparam int ACR_B_DRV = 0;
  localparam int ACR_B_XFER = 0;
  localparam int ACR_B_CLKSEL = 4;
  // Frame layout
  localparam logic [4:0] ACR_BIT_INSTR_END = 5'd15;
  localparam logic [4:0] ACR_BIT_LAST = 5'd23;
  typedef enum logic [1:0] {ACR_PM_NORMAL, ACR_PM_POWERDOWN_PIN, ACR_PM_STBY, ACR_PM_DRST} acr_pmode_t;
  typedef enum {ACR_SPI_IDLE, ACR_SPI_INSTR, ACR_SPI_DATA} acr_spi_t;
endpackage

// File: design/acr_regs.sv
// Serial control port and register bank of the quad converter
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NCLK = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic spi_mode,
  input wire logic powerdown_pin,
  output logic datapath_clk_en,
  output logic datapath_reset,
  output logic outputs_en,
  output logic dcs_en,
  output logic chop_en,
  output logic [NCH-1:0] chan_powerdown,
  output logic [NCH-1:0] chan_output_reset,
  output logic [NCH-1:0] reduced_range,
  output logic [NCH-1:0] output_invert,
  output logic [NCH-1:0] twos_complement,
  output logic [NCLK-1:0] clk_drive_2x,
  output logic [2*NCLK-1:0] clk_term_sel,
  output logic [7:0] output_phase,
  output logic [7:0] rate_active,
  output logic sdio_pulldown_off,
  output logic common_mode_reference_pd,
  output logic [1:0] sync_ctrl
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  // Idle levels at reset, power-down pin low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 5'h1E;
      sync_q <= 5'h1E;
    end else begin
      meta_q <= {spi_sclk, spi_csb, sdio_in, spi_mode, powerdown_pin};
      sync_q <= meta_q;
    end
  end
  logic sclk_s, csb_s, sdi_s, mode_s, pdpin_s;
  assign {sclk_s, csb_s, sdi_s, mode_s, pdpin_s} = sync_q;

  // ****************************************
  // Serial frame engine
  // ****************************************
  acr_spi_t st_q, st_d;
  logic sclk_q, sclk_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic rd_q, rd_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0] osh_q, osh_d;
  logic out_q, out_d;
  logic oe_q, oe_d;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_val;
  logic rise, fall;
  assign rise = sclk_s && !sclk_q;
  assign fall = !sclk_s && sclk_q;

  always_comb begin
    st_d = st_q;
    sclk_d = sclk_s;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    addr_d = addr_q;
    osh_d = osh_q;
    out_d = out_q;
    oe_d = oe_q;
    wr_stb = 1'b0;
    wr_data = {sh_q[6:0], sdi_s};
    if (csb_s) begin
      st_d = ACR_SPI_IDLE;
      oe_d = 1'b0;
      cnt_d = 5'd0;
    end else begin
      case (st_q)
        ACR_SPI_IDLE: begin
          st_d = ACR_SPI_INSTR;
          cnt_d = 5'd0;
        end
        ACR_SPI_INSTR: begin
          if (rise) begin
            sh_d = {sh_q[14:0], sdi_s};
            cnt_d = cnt_q + 5'd1;
            if (cnt_q == ACR_BIT_INSTR_END) begin
              rd_d = sh_q[14];
              addr_d = {sh_q[11:0], sdi_s};
              osh_d = 8'h00;
              st_d = ACR_SPI_DATA;
            end
          end
        end
        ACR_SPI_DATA: begin
          if (fall && rd_q) begin
            osh_d = (cnt_q == 5'd16) ? {rd_val[6:0], 1'b0} : {osh_q[6:0], 1'b0};
            out_d = (cnt_q == 5'd16) ? rd_val[7] : osh_q[7];
            oe_d = 1'b1;
          end
          if (rise) begin
            sh_d = {sh_q[14:0], sdi_s};
            cnt_d = cnt_q + 5'd1;
            if (cnt_q == ACR_BIT_LAST) begin
              wr_stb = !rd_q;
              cnt_d = 5'd16;
              addr_d = addr_q + 13'd1;
            end
          end
        end
        default: st_d = ACR_SPI_IDLE;
      endcase
    end
  end

  // Only power-on reset clears the serial port
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= ACR_SPI_IDLE;
      sclk_q <= 1'b1;
      cnt_q <= 5'd0;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      addr_q <= 13'h0000;
      osh_q <= 8'h00;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      osh_q <= osh_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end
  assign sdio_out = out_q;
  assign sdio_oe = oe_q;

  // ****************************************
  // Global registers
  // ****************************************
  logic [7:0] idx_a_q, idx_a_d, idx_b_q, idx_b_d, pwr_q, pwr_d, clk_q, clk_d;
  logic [7:0] enh_q, enh_d, ophase_q, ophase_d, rate_q, rate_d, ract_q, ract_d;
  logic [7:0] io2_q, io2_d, io3_q, io3_d, sync_q2, sync_d2;
  logic [7:0] omode_q [NCH];
  logic [7:0] chpwr_q [NCH];
  logic [7:0] oadj_q [NCLK];
  logic [$clog2(NCH)-1:0] rd_ch;
  logic [$clog2(NCLK)-1:0] rd_ck;

  always_comb begin
    idx_a_d = idx_a_q;
    idx_b_d = idx_b_q;
    pwr_d = pwr_q;
    clk_d = clk_q;
    enh_d = enh_q;
    ophase_d = ophase_q;
    rate_d = rate_q;
    ract_d = ract_q;
    io2_d = io2_q;
    io3_d = io3_q;
    sync_d2 = sync_q2;
    if (wr_stb) begin
      case (addr_q)
        ACR_IDX_A: idx_a_d = wr_data & ACR_M_IDX_A;
        ACR_IDX_B: idx_b_d = wr_data & ACR_M_IDX_B;
        ACR_PWR: pwr_d = wr_data & ACR_M_PWR;
        ACR_CLK: clk_d = wr_data & ACR_M_CLK;
        ACR_ENH: enh_d = wr_data & ACR_M_ENH;
        ACR_OPHASE: ophase_d = wr_data & ACR_M_OPHASE;
        ACR_RATE: rate_d = wr_data & ACR_M_RATE;
        ACR_XFER: if (wr_data[ACR_B_XFER]) ract_d = rate_q;
        ACR_IO2: io2_d = wr_data & ACR_M_IO2;
        ACR_IO3: io3_d = wr_data & ACR_M_IO3;
        ACR_SYNC: sync_d2 = wr_data & ACR_M_SYNC;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idx_a_q <= ACR_R_IDX_A;
      idx_b_q <= ACR_R_IDX_B;
      pwr_q <= ACR_R_ZERO;
      clk_q <= ACR_R_CLK;
      enh_q <= ACR_R_ZERO;
      ophase_q <= ACR_R_OPHASE;
      rate_q <= ACR_R_ZERO;
      ract_q <= ACR_R_ZERO;
      io2_q <= ACR_R_ZERO;
      io3_q <= ACR_R_ZERO;
      sync_q2 <= ACR_R_ZERO;
    end else begin
      idx_a_q <= idx_a_d;
      idx_b_q <= idx_b_d;
      pwr_q <= pwr_d;
      clk_q <= clk_d;
      enh_q <= enh_d;
      ophase_q <= ophase_d;
      rate_q <= rate_d;
      ract_q <= ract_d;
      io2_q <= io2_d;
      io3_q <= io3_d;
      sync_q2 <= sync_d2;
    end
  end

  // ****************************************
  // Per-channel registers
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [7:0] om_d, cp_d;
    always_comb begin
      om_d = omode_q[c];
      cp_d = chpwr_q[c];
      if (wr_stb && idx_b_q[c]) begin
        if (addr_q == ACR_OMODE) om_d = wr_data & ACR_M_OMODE;
        if (addr_q == ACR_CHPWR) cp_d = wr_data & ACR_M_CHPWR;
      end
    end
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        omode_q[c] <= ACR_R_OMODE;
        chpwr_q[c] <= ACR_R_ZERO;
      end else begin
        omode_q[c] <= om_d;
        chpwr_q[c] <= cp_d;
      end
    end
    assign reduced_range[c] = omode_q[c][ACR_B_RANGE];
    assign output_invert[c] = omode_q[c][ACR_B_INV];
    assign twos_complement[c] = omode_q[c][ACR_B_TWOS];
    assign chan_powerdown[c] = chpwr_q[c][0];
    assign chan_output_reset[c] = chpwr_q[c][1];
  end

  for (genvar k = 0; k < NCLK; k++) begin : g_ck
    logic [7:0] oa_d;
    always_comb begin
      oa_d = oadj_q[k];
      if (wr_stb && idx_b_q[ACR_B_CLKSEL+k] && addr_q == ACR_OADJ) begin
        oa_d = wr_data & ACR_M_OADJ;
      end
    end
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        oadj_q[k] <= ACR_R_ZERO;
      end else begin
        oadj_q[k] <= oa_d;
      end
    end
    assign clk_term_sel[2*k +: 2] = oadj_q[k][5:4];
    assign clk_drive_2x[k] = oadj_q[k][ACR_B_DRV] && (oadj_q[k][5:4] == 2'b00);
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rd_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (idx_b_q[i]) rd_ch = i[$clog2(NCH)-1:0];
    end
    rd_ck = '0;
    for (int j = NCLK - 1; j >= 0; j--) begin
      if (idx_b_q[ACR_B_CLKSEL+j]) rd_ck = j[$clog2(NCLK)-1:0];
    end
    case (addr_d)
      ACR_IDX_A: rd_val = idx_a_q;
      ACR_IDX_B: rd_val = idx_b_q;
      ACR_PWR: rd_val = pwr_q;
      ACR_CLK: rd_val = clk_q;
      ACR_ENH: rd_val = enh_q;
      ACR_OMODE: rd_val = omode_q[rd_ch];
      ACR_OADJ: rd_val = oadj_q[rd_ck];
      ACR_OPHASE: rd_val = ophase_q;
      ACR_CHPWR: rd_val = chpwr_q[rd_ch];
      ACR_RATE: rd_val = rate_q;
      ACR_IO2: rd_val = io2_q;
      ACR_IO3: rd_val = io3_q;
      ACR_SYNC: rd_val = sync_q2;
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // Power mode decode
  // ****************************************
  acr_pmode_t pm;
  always_comb begin
    pm = acr_pmode_t'(pwr_q[1:0]);
    if (pdpin_s) pm = pwr_q[ACR_B_PINSTBY] ? ACR_PM_STBY : ACR_PM_POWERDOWN_PIN;
    case (pm)
      ACR_PM_NORMAL: {datapath_clk_en, datapath_reset, outputs_en} = 3'b101;
      ACR_PM_POWERDOWN_PIN: {datapath_clk_en, datapath_reset, outputs_en} = 3'b010;
      ACR_PM_STBY: {datapath_clk_en, datapath_reset, outputs_en} = 3'b000;
      ACR_PM_DRST: {datapath_clk_en, datapath_reset, outputs_en} = 3'b010;
      default: {datapath_clk_en, datapath_reset, outputs_en} = 3'b010;
    endcase
  end

  assign dcs_en = !mode_s || !clk_q[ACR_B_DCS];
  assign chop_en = enh_q[ACR_B_CHOP];
  assign output_phase = ophase_q;
  assign rate_active = ract_q;
  assign sdio_pulldown_off = io2_q[0];
  assign common_mode_reference_pd = io3_q[3];
  assign sync_ctrl = sync_q2[1:0];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_rate_hold: assert property (!(wr_stb && addr_q == ACR_XFER) |=> $stable(rate_active))
    else $error("rate active changed without transfer");
  a_rate_load: assert property (wr_stb && addr_q == ACR_XFER && wr_data[0]
    |=> rate_active == $past(rate_q)) else $error("transfer did not load rate");
  a_write_now: assert property (wr_stb && addr_q == ACR_ENH
    |=> chop_en == $past(wr_data[2])) else $error("chop not updated at once");
  a_chan_sel: assert property (wr_stb && addr_q == ACR_OMODE && !idx_b_q[0]
    |=> $stable(omode_q[0])) else $error("unselected channel written");
  a_powerdown_pin_out: assert property (!pdpin_s && pwr_q[1:0] == 2'b01
    |-> datapath_reset && !datapath_clk_en && !outputs_en) else $error("power-down wrong");
  a_stby_out: assert property (pdpin_s && pwr_q[5]
    |-> !datapath_reset && !outputs_en) else $error("pin standby wrong");
  a_normal_run: assert property (!pdpin_s && pwr_q[1:0] == 2'b00
    |-> datapath_clk_en && outputs_en && !datapath_reset) else $error("normal mode wrong");
  a_term_wins: assert property (oadj_q[0][5:4] != 2'b00 |-> !clk_drive_2x[0])
    else $error("double drive with termination");
  a_open_zero: assert property (io3_q[7:4] == 4'h0 && pwr_q[7:6] == 2'b00)
    else $error("open bits set");
  a_dcs_pin: assert property (!mode_s |-> dcs_en) else $error("stabilizer off without port");
  // Mode field decode with pin released, then pin power-down
  a_stby_mode: assert property (!pdpin_s && pwr_q[1:0] == 2'b10
    |-> !datapath_clk_en && !datapath_reset && !outputs_en) else $error("standby wrong");
  a_drst_mode: assert property (!pdpin_s && pwr_q[1:0] == 2'b11
    |-> datapath_reset && !datapath_clk_en) else $error("digital reset wrong");
  a_pin_powerdown_pin: assert property (pdpin_s && !pwr_q[ACR_B_PINSTBY]
    |-> datapath_reset && !outputs_en) else $error("pin power-down wrong");
  // Serial port keeps running in every mode
  a_port_live: assert property (st_q == ACR_SPI_IDLE && !csb_s
    |=> st_q == ACR_SPI_INSTR) else $error("serial port did not start");
  a_clk_sel: assert property (wr_stb && addr_q == ACR_OADJ && !idx_b_q[ACR_B_CLKSEL+1]
    |=> $stable(oadj_q[1])) else $error("unselected clock channel written");
  a_range_sel: assert property (wr_stb && addr_q == ACR_OMODE && idx_b_q[1]
    |=> reduced_range[1] == $past(wr_data[ACR_B_RANGE])) else $error("range not written");
  a_chop_hold: assert property (!(wr_stb && addr_q == ACR_ENH)
    |=> $stable(chop_en)) else $error("chop changed without write");

  // ****************************************
  // Cover points
  // ****************************************
  c_write: cover property (wr_stb ##[1:100] wr_stb);
  c_read: cover property (sdio_oe [*8]);
  c_xfer: cover property (wr_stb && addr_q == ACR_XFER && wr_data[0]);
  c_pin_pd: cover property (pdpin_s && !pwr_q[5]);
  c_drst: cover property (!pdpin_s && pwr_q[1:0] == 2'b11);
endmodule

// File: test/acr_spi_host.sv
// SPI host model that frames register accesses to the converter
`timescale 1ns/1ps
module acr_spi_host (
  input wire logic clock,
  output logic spi_sclk,
  output logic spi_csb,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic host_bit;
  // Wire level: device drive wins, else host, pull-down when idle
  assign sdio_in = sdio_oe ? sdio_out : host_bit;
  initial begin
    spi_sclk = 1'b0;
    spi_csb = 1'b1;
    host_bit = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One 24-bit frame, MSB first, slow enough for the synchronisers
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                      output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, 2'b00, addr, wd};
    rdata = 8'h00;
    spi_csb = 1'b0;
    wait_clk(4);
    for (int i = 23; i >= 0; i--) begin
      host_bit = frame[i];
      wait_clk(5);
      if (rd && i < 8) rdata[i] = sdio_in;
      spi_sclk = 1'b1;
      wait_clk(4);
      spi_sclk = 1'b0;
    end
    wait_clk(6);
    spi_csb = 1'b1;
    host_bit = 1'b0;
    wait_clk(6);
  endtask
endmodule

// File: test/adc_control_register_map_tb.sv
// Self-checking bench of the converter control register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module adc_control_register_map_tb
  import acr_pkg::*;
();
  logic clock, resetn, spi_sclk, spi_csb, sdio_in, sdio_out, sdio_oe, spi_mode, powerdown_pin;
  logic datapath_clk_en, datapath_reset, outputs_en, dcs_en, chop_en;
  logic sdio_pulldown_off, common_mode_reference_pd;
  logic [3:0] chan_powerdown, chan_output_reset, reduced_range, output_invert, twos_complement;
  logic [1:0] clk_drive_2x, sync_ctrl;
  logic [3:0] clk_term_sel;
  logic [7:0] output_phase, rate_active;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  acr_spi_host i_host (.clock(clock), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));
  acr_regs i_dut (.clock(clock), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .spi_mode(spi_mode),
    .powerdown_pin(powerdown_pin), .datapath_clk_en(datapath_clk_en),
    .datapath_reset(datapath_reset), .outputs_en(outputs_en), .dcs_en(dcs_en),
    .chop_en(chop_en), .chan_powerdown(chan_powerdown), .chan_output_reset(chan_output_reset),
    .reduced_range(reduced_range), .output_invert(output_invert),
    .twos_complement(twos_complement), .clk_drive_2x(clk_drive_2x),
    .clk_term_sel(clk_term_sel), .output_phase(output_phase), .rate_active(rate_active),
    .sdio_pulldown_off(sdio_pulldown_off),
    .common_mode_reference_pd(common_mode_reference_pd), .sync_ctrl(sync_ctrl));
  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] rd;
    i_host.xfer(1'b0, a, d, rd);
  endtask
  task automatic rd_chk(input string nm, input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    i_host.xfer(1'b1, a, 8'h00, rd);
    `CHK(nm, exp, rd)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    rd_chk("clock_control", ACR_CLK, 8'h01);
    rd_chk("output_mode", ACR_OMODE, 8'h01);
    `CHK("dcs_en", 1'b0, dcs_en)
    `CHK("twos_complement", 4'hF, twos_complement)
    `CHK("reduced_range", 4'h0, reduced_range)
    `CHK("rate_active", 8'h00, rate_active)
  endtask
  task automatic t_open_bits();
    logic [12:0] adr [8] = '{ACR_CLK, ACR_ENH, ACR_OMODE, ACR_IO2, ACR_IO3, ACR_SYNC, ACR_CHPWR,
      ACR_OPHASE};
    logic [7:0] msk [8] = '{8'h01, 8'h04, 8'h45, 8'h01, 8'h08, 8'h03, 8'h03, 8'h7F};
    for (int i = 0; i < 8; i++) begin
      wr(adr[i], 8'hFF);
      rd_chk("masked readback", adr[i], msk[i]);
    end
    wr(13'h1FFF, 8'hFF);
    rd_chk("unmapped", 13'h1FFF, 8'h00);
    `CHK("chop_en", 1'b1, chop_en)
    `CHK("output_invert", 4'hF, output_invert)
    `CHK("reduced_range", 4'hF, reduced_range)
    `CHK("chan_powerdown", 4'hF, chan_powerdown)
    `CHK("chan_output_reset", 4'hF, chan_output_reset)
    `CHK("output_phase", 8'h7F, output_phase)
    `CHK("sync_ctrl", 2'b11, sync_ctrl)
    `CHK("io pins", 2'b11, {sdio_pulldown_off, common_mode_reference_pd})
    wr(ACR_ENH, 8'h00);
    `CHK("chop_en", 1'b0, chop_en)
  endtask
  task automatic t_power_modes();
    logic [2:0] exp [4] = '{3'b101, 3'b010, 3'b000, 3'b010};
    for (int m = 0; m < 4; m++) begin
      wr(ACR_PWR, 8'(m));
      `CHK("clk rst out", exp[m], {datapath_clk_en, datapath_reset, outputs_en})
    end
    rd_chk("power_modes", ACR_PWR, 8'h03);
    wr(ACR_PWR, 8'h20);
    powerdown_pin = 1'b1;
    i_host.wait_clk(4);
    `CHK("pin standby", 3'b000, {datapath_clk_en, datapath_reset, outputs_en})
    wr(ACR_PWR, 8'h00);
    `CHK("pin powerdown", 3'b010, {datapath_clk_en, datapath_reset, outputs_en})
    powerdown_pin = 1'b0;
    i_host.wait_clk(4);
    `CHK("normal", 3'b101, {datapath_clk_en, datapath_reset, outputs_en})
  endtask
  task automatic t_rate_commit();
    wr(ACR_RATE, 8'hC1);
    `CHK("rate held", 8'h00, rate_active)
    rd_chk("rate_override", ACR_RATE, 8'h41);
    wr(ACR_XFER, 8'h01);
    `CHK("rate applied", 8'h41, rate_active)
    rd_chk("transfer_commit", ACR_XFER, 8'h00);
  endtask
  task automatic t_no_spi();
    spi_mode = 1'b0;
    i_host.wait_clk(4);
    `CHK("dcs forced", 1'b1, dcs_en)
    spi_mode = 1'b1;
    i_host.wait_clk(4);
    `CHK("dcs off", 1'b0, dcs_en)
    wr(ACR_CLK, 8'h00);
    `CHK("dcs on", 1'b1, dcs_en)
  endtask
  task automatic t_chan_select();
    wr(ACR_IDX_A, 8'h01);
    wr(ACR_IDX_B, 8'h11);
    wr(ACR_OMODE, 8'h00);
    `CHK("twos per channel", 4'hE, twos_complement)
    `CHK("invert per channel", 4'hE, output_invert)
    rd_chk("output_mode ch0", ACR_OMODE, 8'h00);
    wr(ACR_OADJ, 8'h01);
    `CHK("drive 2x", 2'b01, clk_drive_2x)
    wr(ACR_OADJ, 8'h11);
    `CHK("term wins", 2'b00, clk_drive_2x)
    `CHK("term sel", 4'h1, clk_term_sel)
    wr(ACR_IDX_A, 8'h02);
    wr(ACR_IDX_B, 8'h02);
    wr(ACR_OMODE, 8'h44);
    `CHK("twos ch1 only", 4'hC, twos_complement)
    `CHK("invert ch1 kept", 4'hE, output_invert)
    rd_chk("output_mode ch1", ACR_OMODE, 8'h44);
  endtask
  task automatic t_reset_again();
    resetn = 1'b0;
    i_host.wait_clk(5);
    resetn = 1'b1;
    i_host.wait_clk(6);
    `CHK("twos after reset", 4'hF, twos_complement)
    `CHK("dcs after reset", 1'b0, dcs_en)
    `CHK("rate after reset", 8'h00, rate_active)
    rd_chk("clock after reset", ACR_CLK, 8'h01);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    spi_mode = 1'b1;
    powerdown_pin = 1'b0;
    i_host.wait_clk(5);
    resetn = 1'b1;
    i_host.wait_clk(6);
    t_reset_values();
    t_open_bits();
    t_power_modes();
    t_rate_commit();
    t_no_spi();
    t_chan_select();
    t_reset_again();
    tally_and_finish();
  end
endmodule
